/* File: core/frp_sequencer.sv */
// Purpose: Row and single-word self-programming sequencer for program flash
// Assumes: CPU strobes are one-cycle pulses synchronous to clk_sys
// Notes: All outputs come from the state register
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Row buffers and row programming exist only when MULTI_BUF is set.
// - Buffers hold table-write data until row programming consumes it.
// - A row is 64 words, loaded by 64 low and 64 high writes.
// - Low address bits of a table write pick the buffer, any order.
// - Row target is captured address with low 7 bits ignored.
// - Control value 0x4001 selects row programming with write enable.
// - Control value 0x4003 selects word programming with write enable.
// - Key 0x55 then 0xAA, then start bit set, begins an operation.
// - Word mode latches one 24-bit word; low bits give its row position.
// - Table page register supplies upper 8 flash address bits.
// - Table write captures lower 16 address bits as program target.
// - Device times the operation and clears the start bit when done.
// - CPU stalls and interrupts stay pending during the operation.
// - Power-on reset aborts; other resets wait until the cycle ends.
module frp_sequencer #(
  parameter int ROW_WORDS = frp_pkg::ROW_WORDS_DEF,
  parameter bit MULTI_BUF = 1'b1,
  parameter int PROG_CYC = frp_pkg::WORD_PROG_CYC
)
(
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Table write port
  input wire logic tw_valid,
  input wire logic tw_high,
  input wire logic [1:0] tw_be,
  input wire logic [15:0] tw_offset,
  input wire logic [15:0] tw_data,
  // Register write port
  input wire logic reg_wr,
  input wire logic [1:0] reg_sel,
  input wire logic [15:0] reg_wdata,
  // Other reset sources
  input wire logic soft_rst_req,
  // Register and status view
  output logic [15:0] flash_control_reg,
  output logic [7:0] table_page_reg,
  output logic cpu_stall,
  output logic irq_hold,
  output logic soft_rst_out,
  // Flash array program port
  output logic fl_prog,
  output logic [23:0] fl_addr,
  output logic [23:0] fl_data
);

  localparam int IW = $clog2(ROW_WORDS);
  localparam logic [23:0] ROW_MASK = 24'(2 * ROW_WORDS - 1);
  localparam logic [15:0] LAST_CNT = 16'(PROG_CYC - 1);

  generate
    if (ROW_WORDS < 2 || ROW_WORDS > 64 || (1 << IW) != ROW_WORDS || PROG_CYC < 1 || PROG_CYC > 65536)
    begin : g_bad_param
      $error("frp_sequencer: unsupported parameters");
    end
  endgenerate

  typedef struct packed {
    frp_pkg::frp_state_t st;
    frp_pkg::frp_key_t key;
    logic [15:0] ctrl;
    logic [7:0] page;
    logic [23:0] tgt;
    logic [23:0] latch;
    logic [ROW_WORDS-1:0][23:0] bufs;
    logic [IW:0] widx;
    logic [15:0] tcnt;
    logic row_op;
    logic stall;
    logic prog;
    logic [23:0] addr;
    logic [23:0] data;
    logic rst_pend;
    logic rst_out;
  } frp_regs_t;

  frp_regs_t state_reg;
  frp_regs_t state_next;
  logic [ROW_WORDS-1:0][23:0] bufs_next;
  logic tw_take;
  logic [IW-1:0] tw_idx;
  logic [23:0] tw_word;
  logic [3:0] wr_op;
  logic start_ok;

  // ==========================================================
  // Table write decode
  assign tw_take = tw_valid && state_reg.st == frp_pkg::ST_IDLE;
  assign tw_idx = tw_offset[IW:1];
  always_comb
  begin
    tw_word = state_reg.latch;
    if (!tw_high)
    begin
      if (tw_be[0])
        tw_word[7:0] = tw_data[7:0];
      if (tw_be[1])
        tw_word[15:8] = tw_data[15:8];
    end
    else if (tw_be[0])
      tw_word[23:16] = tw_data[7:0];
  end

  // ==========================================================
  // Holding buffers, one entry per row word
  genvar g;
  generate
    for (g = 0; g < ROW_WORDS; g++)
    begin : g_buf
      if (MULTI_BUF)
      begin : g_on
        logic [23:0] cur;
        assign cur = state_reg.bufs[g];
        always_comb
        begin
          bufs_next[g] = cur;
          if (tw_take && tw_idx == IW'(g))
          begin
            if (!tw_high)
            begin
              if (tw_be[0])
                bufs_next[g][7:0] = tw_data[7:0];
              if (tw_be[1])
                bufs_next[g][15:8] = tw_data[15:8];
            end
            else if (tw_be[0])
              bufs_next[g][23:16] = tw_data[7:0];
          end
        end
      end
      else
      begin : g_off
        assign bufs_next[g] = 24'h000000;
      end
    end
  endgenerate

  // ==========================================================
  // Start qualification
  assign wr_op = reg_wdata[frp_pkg::OP_LSB +: frp_pkg::OP_W];
  assign start_ok = (wr_op == frp_pkg::OP_WORD) || (MULTI_BUF && wr_op == frp_pkg::OP_ROW);

  always_comb
  begin
    state_next = state_reg;
    state_next.bufs = bufs_next;
    state_next.prog = 1'b0;
    state_next.rst_out = 1'b0;
    case (state_reg.st)
      frp_pkg::ST_IDLE:
      begin
        if (state_reg.rst_pend)
        begin
          state_next.rst_out = 1'b1;
          state_next.rst_pend = 1'b0;
        end
        if (tw_take)
        begin
          state_next.tgt = {state_reg.page, tw_offset};
          state_next.latch = tw_word;
          state_next.key = frp_pkg::KEY_NONE;
        end
        if (reg_wr)
        begin
          state_next.key = frp_pkg::KEY_NONE;
          case (reg_sel)
            frp_pkg::SEL_CTRL:
            begin
              state_next.ctrl = reg_wdata & frp_pkg::CTRL_WMASK;
              if (reg_wdata[frp_pkg::CTRL_START_BIT] && state_reg.key == frp_pkg::KEY_OPEN)
              begin
                if (start_ok && reg_wdata[frp_pkg::CTRL_WREN_BIT])
                begin
                  state_next.ctrl[frp_pkg::CTRL_START_BIT] = 1'b1;
                  state_next.st = frp_pkg::ST_PROG;
                  state_next.stall = 1'b1;
                  state_next.row_op = (wr_op == frp_pkg::OP_ROW);
                  state_next.widx = '0;
                  state_next.tcnt = 16'h0000;
                end
                else
                  state_next.ctrl[frp_pkg::CTRL_ERR_BIT] = 1'b1;
              end
            end
            frp_pkg::SEL_KEY:
            begin
              if (reg_wdata[7:0] == frp_pkg::KEY_FIRST)
                state_next.key = frp_pkg::KEY_HALF;
              else if (reg_wdata[7:0] == frp_pkg::KEY_SECOND && state_reg.key == frp_pkg::KEY_HALF)
                state_next.key = frp_pkg::KEY_OPEN;
            end
            frp_pkg::SEL_PAGE:
              state_next.page = reg_wdata[7:0];
            default:
              state_next.key = frp_pkg::KEY_NONE;
          endcase
        end
      end
      frp_pkg::ST_PROG:
      begin
        state_next.tcnt = state_reg.tcnt + 16'h0001;
        if (state_reg.tcnt == LAST_CNT)
        begin
          state_next.tcnt = 16'h0000;
          state_next.prog = 1'b1;
          if (state_reg.row_op)
          begin
            state_next.addr = (state_reg.tgt & ~ROW_MASK) | 24'({state_reg.widx[IW-1:0], 1'b0});
            state_next.data = state_reg.bufs[state_reg.widx[IW-1:0]];
          end
          else
          begin
            state_next.addr = state_reg.tgt;
            state_next.data = state_reg.latch;
          end
          state_next.widx = state_reg.widx + (IW+1)'(1);
          if (!state_reg.row_op || state_reg.widx == (IW+1)'(ROW_WORDS - 1))
            state_next.st = frp_pkg::ST_FIN;
        end
      end
      frp_pkg::ST_FIN:
      begin
        state_next.ctrl[frp_pkg::CTRL_START_BIT] = 1'b0;
        state_next.stall = 1'b0;
        state_next.st = frp_pkg::ST_IDLE;
      end
      default:
        state_next.st = frp_pkg::ST_IDLE;
    endcase
    if (soft_rst_req)
      state_next.rst_pend = 1'b1;
  end

  // ==========================================================
  // State register; rst_b is the power-on reset and aborts work
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= '{st: frp_pkg::ST_IDLE, key: frp_pkg::KEY_NONE, ctrl: frp_pkg::CTRL_RESET,
                     page: frp_pkg::PAGE_RESET, default: '0};
    else
      state_reg <= state_next;
  end

  assign flash_control_reg = state_reg.ctrl;
  assign table_page_reg = state_reg.page;
  assign cpu_stall = state_reg.stall;
  assign irq_hold = state_reg.stall;
  assign soft_rst_out = state_reg.rst_out;
  assign fl_prog = state_reg.prog;
  assign fl_addr = state_reg.addr;
  assign fl_data = state_reg.data;

  // ==========================================================
  // Checks
  logic [7:0] pulse_cnt;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      pulse_cnt <= 8'h00;
    else if (state_reg.st == frp_pkg::ST_IDLE)
      pulse_cnt <= 8'h00;
    else if (state_reg.prog)
      pulse_cnt <= pulse_cnt + 8'h01;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_unlock;
    reg_wr && reg_sel == frp_pkg::SEL_KEY && reg_wdata[7:0] == frp_pkg::KEY_FIRST ##1
    reg_wr && reg_sel == frp_pkg::SEL_KEY && reg_wdata[7:0] == frp_pkg::KEY_SECOND;
  endsequence

  sequence s_go_word;
    reg_wr && reg_sel == frp_pkg::SEL_CTRL && reg_wdata == 16'hC003;
  endsequence

  sequence s_op_end;
    state_reg.st == frp_pkg::ST_FIN;
  endsequence

  unlock_start_a: assert property (state_reg.st == frp_pkg::ST_IDLE && !tw_valid
    ##0 s_unlock ##1 (s_go_word and !tw_valid) |=> cpu_stall && flash_control_reg[15])
    else $error("keyed start did not begin");
  nokey_ignore_a: assert property (state_reg.st == frp_pkg::ST_IDLE && reg_wr && reg_sel == frp_pkg::SEL_CTRL
    && state_reg.key != frp_pkg::KEY_OPEN |=> !cpu_stall && !flash_control_reg[15])
    else $error("start taken without key");
  start_clear_a: assert property (s_op_end |=> !flash_control_reg[15] && !cpu_stall)
    else $error("start bit not cleared at end");
  stall_span_a: assert property ($rose(cpu_stall) |-> irq_hold ##1 (state_reg.st == frp_pkg::ST_PROG))
    else $error("stall without program state");
  // The last strobe is counted on the edge that leaves the end state
  row_count_a: assert property (s_op_end and state_reg.row_op |=> pulse_cnt == 8'(ROW_WORDS))
    else $error("row did not program every word");
  word_count_a: assert property (s_op_end and !state_reg.row_op |=> pulse_cnt == 8'h01)
    else $error("word op programmed wrong count");
  row_align_a: assert property (fl_prog && state_reg.row_op |->
    (fl_addr & ~ROW_MASK) == (state_reg.tgt & ~ROW_MASK) && (fl_addr & ROW_MASK) == 24'({pulse_cnt[IW-1:0], 1'b0}))
    else $error("row address not aligned");
  prog_space_a: assert property (fl_prog |=> !fl_prog)
    else $error("program pulses too close");
  soft_rst_a: assert property (soft_rst_req && state_reg.st == frp_pkg::ST_PROG |=> !soft_rst_out)
    else $error("reset not held pending");
  phantom_a: assert property (tw_take && tw_high && !tw_be[0] |=> state_reg.latch == $past(state_reg.latch))
    else $error("phantom byte write changed latch");
  capture_a: assert property (tw_take |=> state_reg.tgt == {$past(state_reg.page), $past(tw_offset)})
    else $error("table address not captured");

endmodule

`default_nettype wire

/* File: core/frp_pkg.sv */
// Purpose: Shared constants and types of the flash row/word program sequencer
// Assumes: 100 MHz system clock
// Notes: Control layout: start 15, write enable 14, error 13, erase 6, op 3:0
package frp_pkg;

  // ==========================================================
  // Control register fields
  localparam int CTRL_START_BIT = 15;
  localparam int CTRL_WREN_BIT = 14;
  localparam int CTRL_ERR_BIT = 13;
  localparam int OP_LSB = 0;
  localparam int OP_W = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h704F;
  localparam logic [3:0] OP_ROW = 4'h1;
  localparam logic [3:0] OP_WORD = 4'h3;

  // ==========================================================
  // Unlock key values and register selects
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_KEY = 2'h1;
  localparam logic [1:0] SEL_PAGE = 2'h2;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // ==========================================================
  // Geometry and timing
  localparam int ROW_WORDS_DEF = 64;
  localparam int SEL_BITS = 7;
  localparam int WORD_W = 24;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WORD_PROG_NS = 20000;
  localparam int WORD_PROG_CYC = (WORD_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_FIN = 3'b100
  } frp_state_t;

  typedef enum logic [1:0]
  {
    KEY_NONE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OPEN = 2'h2
  } frp_key_t;

endpackage

/* File: dv/frp_flash_model.sv */
// Purpose: Program flash array model that records every program strobe
// Assumes: One-cycle program strobes synchronous to clk_sys
// Notes: Bench reads the recorded address and data lists by hierarchy
`timescale 1ns/10ps
`default_nettype none

module frp_flash_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Program port
  input wire logic fl_prog,
  input wire logic [23:0] fl_addr,
  input wire logic [23:0] fl_data
);
  logic [23:0] addr_q [0:255];
  logic [23:0] data_q [0:255];
  int n_prog = 0;

  // ==========================================================
  // Capture each programmed word
  always @(posedge clk_sys)
  begin
    if (rst_b && fl_prog === 1'b1)
    begin
      addr_q[n_prog] <= fl_addr;
      data_q[n_prog] <= fl_data;
      n_prog <= n_prog + 1;
    end
  end
endmodule

`default_nettype wire

/* File: dv/frp_sequencer_tb.sv */
// Purpose: Self-checking bench of the flash row/word program sequencer
// Assumes: Program time shortened to 4 cycles per word
// Notes: Strobes are raised on one edge and dropped on the next, except reg_wr, held for three cycles in start_op
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module frp_sequencer_tb;
  logic clk_sys = 1'b0, rst_b = 1'b0, tw_valid = 1'b0, tw_high = 1'b0, reg_wr = 1'b0, soft_rst_req = 1'b0;
  logic [1:0] tw_be = 2'h0, reg_sel = 2'h0;
  logic [15:0] tw_offset = 16'h0000, tw_data = 16'h0000, reg_wdata = 16'h0000, flash_control_reg;
  logic [7:0] table_page_reg;
  logic cpu_stall, irq_hold, soft_rst_out, fl_prog;
  logic [23:0] fl_addr, fl_data;
  int n_fail = 0, check_count = 0, soft_total = 0, soft_busy = 0, base;

  frp_sequencer #(.ROW_WORDS(64), .MULTI_BUF(1'b1), .PROG_CYC(4)) i_frp_sequencer (.clk_sys(clk_sys),
    .rst_b(rst_b), .tw_valid(tw_valid), .tw_high(tw_high), .tw_be(tw_be), .tw_offset(tw_offset),
    .tw_data(tw_data), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .soft_rst_req(soft_rst_req),
    .flash_control_reg(flash_control_reg), .table_page_reg(table_page_reg), .cpu_stall(cpu_stall),
    .irq_hold(irq_hold), .soft_rst_out(soft_rst_out), .fl_prog(fl_prog), .fl_addr(fl_addr), .fl_data(fl_data));
  frp_flash_model i_frp_flash_model (.clk_sys(clk_sys), .rst_b(rst_b), .fl_prog(fl_prog), .fl_addr(fl_addr),
    .fl_data(fl_data));

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Count forwarded resets, and those that leak out while stalled
  always @(posedge clk_sys)
  begin
    if (soft_rst_out === 1'b1)
    begin
      soft_total++;
      if (cpu_stall !== 1'b0)
        soft_busy++;
    end
  end

  // ==========================================================
  // Access tasks
  task automatic reg_w(input logic [1:0] sel, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_sel <= sel;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic tw_w(input logic hi, input logic [1:0] be, input logic [15:0] off, input logic [15:0] d);
    @(posedge clk_sys);
    tw_valid <= 1'b1;
    tw_high <= hi;
    tw_be <= be;
    tw_offset <= off;
    tw_data <= d;
    @(posedge clk_sys);
    tw_valid <= 1'b0;
  endtask

  // Unlock pair with nothing between, then the start write
  task automatic start_op(input logic [15:0] ctrl);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_sel <= frp_pkg::SEL_KEY;
    reg_wdata <= 16'h0055;
    @(posedge clk_sys);
    reg_wdata <= 16'h00AA;
    @(posedge clk_sys);
    reg_sel <= frp_pkg::SEL_CTRL;
    reg_wdata <= ctrl;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("stall", 1'b1, cpu_stall)
    `CHK("irq hold", 1'b1, irq_hold)
    `CHK("start bit", 1'b1, flash_control_reg[15])
  endtask

  task automatic wait_done();
    for (int k = 0; k < 600 && cpu_stall !== 1'b0; k++)
      @(posedge clk_sys);
    `CHK("start clear", 1'b0, flash_control_reg[15])
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    `CHK("ctrl reset", frp_pkg::CTRL_RESET, flash_control_reg)
    `CHK("page reset", frp_pkg::PAGE_RESET, table_page_reg)
    $display("test reset done");

    // Word program, erased target assumed, phantom byte write ignored
    reg_w(frp_pkg::SEL_PAGE, 16'h0012);
    tw_w(1'b0, 2'h3, 16'h0104, 16'hBEEF);
    tw_w(1'b1, 2'h3, 16'h0104, 16'h77A5);
    tw_w(1'b1, 2'h2, 16'h0104, 16'h3300);
    `CHK("page", 8'h12, table_page_reg)
    reg_w(frp_pkg::SEL_CTRL, 16'h4003);
    @(posedge clk_sys);
    `CHK("word ctrl", 16'h4003, flash_control_reg)
    base = i_frp_flash_model.n_prog;
    start_op(16'hC003);
    soft_rst_req <= 1'b1;
    @(posedge clk_sys);
    soft_rst_req <= 1'b0;
    wait_done();
    repeat (3) @(posedge clk_sys);
    `CHK("word count", base + 1, i_frp_flash_model.n_prog)
    `CHK("word addr", 24'h120104, i_frp_flash_model.addr_q[base])
    `CHK("word data", 24'hA5BEEF, i_frp_flash_model.data_q[base])
    `CHK("soft pending", 0, soft_busy)
    `CHK("soft out", 1, soft_total)
    $display("test word done");

    // Key broken by an intervening access: start must be ignored
    reg_w(frp_pkg::SEL_KEY, 16'h0055);
    reg_w(frp_pkg::SEL_PAGE, 16'h0003);
    reg_w(frp_pkg::SEL_KEY, 16'h00AA);
    reg_w(frp_pkg::SEL_CTRL, 16'hC003);
    repeat (10) @(posedge clk_sys);
    `CHK("bad key stall", 1'b0, cpu_stall)
    `CHK("bad key start", 1'b0, flash_control_reg[15])
    `CHK("bad key count", base + 1, i_frp_flash_model.n_prog)
    $display("test bad key done");

    // Row program, all 64 words loaded in scattered order (37*i mod 64)
    reg_w(frp_pkg::SEL_CTRL, 16'h4001);
    @(posedge clk_sys);
    `CHK("row ctrl", 16'h4001, flash_control_reg)
    for (int i = 0; i < 64; i++)
    begin
      base = (i * 37) % 64;
      tw_w(1'b1, 2'h1, 16'h0280 | 16'(base << 1), 16'(8'h40 + base));
      tw_w(1'b0, 2'h3, 16'h0280 | 16'(base << 1), 16'h1100 + 16'(base));
    end
    base = i_frp_flash_model.n_prog;
    start_op(16'hC001);
    wait_done();
    `CHK("row count", base + 64, i_frp_flash_model.n_prog)
    for (int i = 0; i < 64; i++)
    begin
      `CHK("row addr", {8'h03, 16'h0280 | 16'(i << 1)}, i_frp_flash_model.addr_q[base + i])
      `CHK("row data", {8'(8'h40 + i), 16'h1100 + 16'(i)}, i_frp_flash_model.data_q[base + i])
    end
    $display("test row done");

    // Power-on reset in mid-operation aborts it
    base = i_frp_flash_model.n_prog;
    reg_w(frp_pkg::SEL_CTRL, 16'h4003);
    start_op(16'hC003);
    rst_b <= 1'b0;
    #1;
    `CHK("abort stall", 1'b0, cpu_stall)
    `CHK("abort ctrl", 16'h0000, flash_control_reg)
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk_sys);
    `CHK("abort count", base, i_frp_flash_model.n_prog)
    $display("test abort done");
    final_report();
  end
endmodule

`default_nettype wire
